//--- verilog/capture_map.svh
// Register map, field positions and timing counts of the capture stacks
//
// Contract
// RL1 - Each of four capture units owns a two-deep stack: top and bottom.
// RL2 - A qualifying input edge captures the selected timer's current count.
// RL3 - A stack read always returns the older count held in top register.
// RL4 - Reading top moves a held bottom value up into top.
// RL5 - Capture into empty stack writes top and sets state to 01.
// RL6 - Reading a one-entry stack returns state to 00.
// RL7 - Capture with one entry writes bottom and sets state to 10.
// RL8 - Reading a two-entry stack outputs top, shifts bottom, state 01.
// RL9 - Capture into full stack drops top, shifts, writes bottom, state 11.
// RL10 - State fields read-only at bits 15-8, unit 4 highest, reset zero.
// RL11 - Writing 1 to low bit x clears state bit x+8; low bits write-only.
// RL12 - Software reads state 11 as two entries plus one more, oldest lost.
// RL13 - Each capture sets its event flag; latency 3.5 to 4.5 clocks; here the flag follows the pin edge by 4 to 5 clocks.
// RL14 - Edge select: 00 none, 01 rising, 10 falling, 11 both.
// RL15 - Disabling a unit stops captures but keeps its stack contents.
// RL16 - Low reset or writing zero to clear-all bit clears everything; that write clears only the stacks and their state here.
// RL17 - Same-cycle read and capture: apply read first, then capture.
// RL18 - Reading an empty stack leaves state 00 and shifts nothing.
`ifndef CAPTURE_MAP_SVH
`define CAPTURE_MAP_SVH

// ==========================================================================
// Addresses
`define CONTROL_ADDR     16'h7420
`define STATE_ADDR       16'h7422
`define STACK1_ADDR      16'h7423
`define STACK2_ADDR      16'h7424
`define STACK3_ADDR      16'h7425
`define STACK4_ADDR      16'h7426

// ==========================================================================
// Control fields
`define CTL_CLEAR_ALL    15
`define CTL_PAIR12_LO    13
`define CTL_EN3          12
`define CTL_EN4          11
`define CTL_TSEL34       10
`define CTL_TSEL12       9
`define CTL_ADC4         8
`define CTL_RESET        16'h0000

// ==========================================================================
// State register
`define STATE_LO         8
`define STATE_RESET      16'h0000

// ==========================================================================
// Capture latency: input sync two clocks plus detect plus latch
`define LATENCY_CYCLES   4

`endif

//--- verilog/capture_pkg.sv
// Types shared by the capture stack design
package capture_pkg;
    typedef enum logic [1:0] {
        STACK_EMPTY = 2'b00,
        STACK_ONE   = 2'b01,
        STACK_TWO   = 2'b10,
        STACK_LOST  = 2'b11
    } stack_state_t;

    typedef enum logic [1:0] {
        EDGE_NONE    = 2'b00,
        EDGE_RISING  = 2'b01,
        EDGE_FALLING = 2'b10,
        EDGE_BOTH    = 2'b11
    } edge_select_t;
endpackage

//--- verilog/edge_detect.sv
// Input synchroniser and selectable edge detector for one capture pin
`timescale 1ns/100ps
module edge_detect
    import capture_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       enable,
    input  wire logic       pin,
    input  wire logic       unit_on,
    input  wire logic [1:0] edge_select,
    output logic            hit
);
    logic       sync1;
    logic       sync2;
    logic       last;
    logic       next_hit;
    logic       rise;
    logic       fall;

    always_comb begin
        rise = sync2 & ~last;
        fall = ~sync2 & last;
        case (edge_select_t'(edge_select)) // RL14
            EDGE_NONE:    next_hit = 1'b0;
            EDGE_RISING:  next_hit = rise;
            EDGE_FALLING: next_hit = fall;
            EDGE_BOTH:    next_hit = rise | fall;
            default:      next_hit = 1'b0;
        endcase
        next_hit = next_hit & unit_on; // RL15
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            last  <= 1'b0;
            hit   <= 1'b0;
        end else if (enable) begin
            sync1 <= pin;
            sync2 <= sync1;
            last  <= sync2;
            hit   <= next_hit;
        end
    end
endmodule

//--- verilog/capture_stack.sv
// Two-deep capture stack with its two-bit state
`timescale 1ns/100ps
module capture_stack
    import capture_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             enable,
    input  wire logic             clear,
    input  wire logic             capture,
    input  wire logic [WIDTH-1:0] count,
    input  wire logic             read,
    input  wire logic [1:0]       clear_bits,
    output logic [WIDTH-1:0]      top,
    output logic [1:0]            state
);
    logic [WIDTH-1:0] bottom;
    logic [WIDTH-1:0] next_top;
    logic [WIDTH-1:0] next_bottom;
    logic [1:0]       next_state;
    logic [1:0]       mid_state;

    always_comb begin
        next_top    = top;
        next_bottom = bottom;
        mid_state   = state;
        // Read first
        if (read) begin // RL17
            case (stack_state_t'(state))
                STACK_EMPTY: mid_state = STACK_EMPTY; // RL18
                STACK_ONE:   mid_state = STACK_EMPTY; // RL6
                default: begin
                    next_top  = bottom; // RL4
                    mid_state = STACK_ONE; // RL8
                end
            endcase
        end
        next_state = mid_state;
        // Then capture
        if (capture) begin
            case (stack_state_t'(mid_state))
                STACK_EMPTY: begin
                    next_top   = count; // RL5
                    next_state = STACK_ONE;
                end
                STACK_ONE: begin
                    next_bottom = count; // RL7
                    next_state  = STACK_TWO;
                end
                default: begin
                    next_top    = bottom; // RL9
                    next_bottom = count;
                    next_state  = STACK_LOST;
                end
            endcase
        end else begin
            // Software clears, capture wins when both land together
            next_state = next_state & ~clear_bits; // RL11
        end
        if (clear) begin // RL16
            next_top    = '0;
            next_bottom = '0;
            next_state  = STACK_EMPTY;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            top    <= '0;
            bottom <= '0;
            state  <= 2'b00;
        end else if (enable) begin // RL1
            top    <= next_top;
            bottom <= next_bottom;
            state  <= next_state;
        end
    end
endmodule

//--- verilog/capture_fifo_stacks.sv
// Four capture units, control and stack state registers
`timescale 1ns/100ps
`include "capture_map.svh"
module capture_fifo_stacks
    import capture_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic             clock_enable,
    input  wire logic [3:0]       capture_pins,
    input  wire logic [WIDTH-1:0] timer2_count,
    input  wire logic [WIDTH-1:0] timer3_count,
    input  wire logic [15:0]      address,
    input  wire logic             read_strobe,
    input  wire logic             write_strobe,
    input  wire logic [15:0]      write_data,
    output logic [15:0]           read_data,
    output logic [3:0]            unit_event_flag,
    output logic                  adc_start
);
    // ======================================================================
    // Reset release
    logic        rst_meta;
    logic        rst_n;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ======================================================================
    // Capture control register
    logic [15:0] capture_control;
    logic [15:0] next_control;
    logic        clear_all;
    logic        ctl_hit;
    logic        state_hit;
    logic [3:0]  stack_hit;

    always_comb begin
        ctl_hit   = write_strobe && address == `CONTROL_ADDR;
        state_hit = write_strobe && address == `STATE_ADDR;
        stack_hit[0] = read_strobe && address == `STACK1_ADDR;
        stack_hit[1] = read_strobe && address == `STACK2_ADDR;
        stack_hit[2] = read_strobe && address == `STACK3_ADDR;
        stack_hit[3] = read_strobe && address == `STACK4_ADDR;
        clear_all    = ctl_hit && !write_data[`CTL_CLEAR_ALL]; // RL16
        next_control = capture_control;
        if (ctl_hit) begin
            next_control = write_data;
            next_control[`CTL_CLEAR_ALL] = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            capture_control <= `CTL_RESET;
        end else if (clock_enable) begin
            capture_control <= next_control;
        end
    end

    // ======================================================================
    // Units
    logic [3:0]       unit_on;
    logic [3:0]       hit;
    logic [3:0]       latch;
    logic [WIDTH-1:0] sel_count [4];
    logic [WIDTH-1:0] tops      [4];
    logic [1:0]       unit_state [4];
    logic [WIDTH-1:0] latched   [4];
    logic [WIDTH-1:0] next_latched [4];
    logic [15:0]      capture_stack_state;
    logic [1:0]       pair_mode;

    always_comb begin
        pair_mode  = capture_control[`CTL_PAIR12_LO +: 2];
        unit_on[0] = pair_mode == 2'b01;
        unit_on[1] = pair_mode == 2'b01;
        unit_on[2] = capture_control[`CTL_EN3];
        unit_on[3] = capture_control[`CTL_EN4];
        sel_count[0] = capture_control[`CTL_TSEL12] ? timer3_count
                                                    : timer2_count;
        sel_count[1] = sel_count[0];
        sel_count[2] = capture_control[`CTL_TSEL34] ? timer3_count
                                                    : timer2_count;
        sel_count[3] = sel_count[2];
        for (int i = 0; i < 4; i++) begin
            next_latched[i] = hit[i] ? sel_count[i] : latched[i]; // RL2
        end
    end

    // Count latched in the cycle after the edge is seen, stored one later
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            latch <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                latched[i] <= '0;
            end
        end else if (clock_enable) begin
            latch <= hit; // RL13
            for (int i = 0; i < 4; i++) begin
                latched[i] <= next_latched[i];
            end
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_unit
        edge_detect u_edge (
            .clock       (clock),
            .rst_n       (rst_n),
            .enable      (clock_enable),
            .pin         (capture_pins[g]),
            .unit_on     (unit_on[g]),
            .edge_select (capture_control[6-2*g +: 2]),
            .hit         (hit[g])
        );
        capture_stack #(.WIDTH(WIDTH)) u_stack (
            .clock      (clock),
            .rst_n      (rst_n),
            .enable     (clock_enable),
            .clear      (clear_all),
            .capture    (latch[g]),
            .count      (latched[g]),
            .read       (stack_hit[g]),
            .clear_bits (state_hit ? write_data[2*g +: 2] : 2'b00),
            .top        (tops[g]), // RL3
            .state      (unit_state[g]) // RL10
        );
    end

    // State fields packed high, write-only clear bits read as zero
    always_comb begin
        capture_stack_state = `STATE_RESET;
        for (int i = 0; i < 4; i++) begin
            capture_stack_state[`STATE_LO+2*i +: 2] = unit_state[i]; // RL10
        end
    end

    // ======================================================================
    // Read data and event outputs
    logic [15:0] next_read_data;
    logic [3:0]  next_flag;
    logic        next_adc;

    always_comb begin
        next_read_data = read_data;
        if (read_strobe) begin
            case (address)
                `CONTROL_ADDR: next_read_data = capture_control;
                `STATE_ADDR:   next_read_data = capture_stack_state;
                `STACK1_ADDR:  next_read_data = 16'(tops[0]);
                `STACK2_ADDR:  next_read_data = 16'(tops[1]);
                `STACK3_ADDR:  next_read_data = 16'(tops[2]);
                `STACK4_ADDR:  next_read_data = 16'(tops[3]);
                default:       next_read_data = 16'h0000;
            endcase
        end
        next_flag = latch; // RL13
        next_adc  = latch[3] & capture_control[`CTL_ADC4];
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            read_data       <= 16'h0000;
            unit_event_flag <= 4'h0;
            adc_start       <= 1'b0;
        end else if (clock_enable) begin
            read_data       <= next_read_data;
            unit_event_flag <= next_flag;
            adc_start       <= next_adc;
        end
    end
endmodule

//--- bench/capture_fifo_stacks_props.sv
// Concurrent checks on the capture stack ports
`timescale 1ns/100ps
`include "capture_map.svh"
module capture_fifo_stacks_props (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        clock_enable,
    input wire logic [3:0]  capture_pins,
    input wire logic [15:0] address,
    input wire logic        read_strobe,
    input wire logic        adc_start,
    input wire logic [15:0] read_data,
    input wire logic [3:0]  unit_event_flag
);
    logic rd_go;

    assign rd_go = read_strobe && clock_enable;

    // ======================================================================
    // Port checks
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    reset_quiet_a: assert property (disable iff (1'b0) (!nrst) [*2] |->
        read_data == 16'h0000 && unit_event_flag == 4'h0)
        else $error("outputs not quiet in reset");
    read_hold_a: assert property (!rd_go |=> $stable(read_data))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (rd_go && address == 16'h7421
        |=> read_data == 16'h0000) else $error("unmapped read not zero");
    state_low_a: assert property (rd_go && address == `STATE_ADDR
        |=> read_data[7:0] == 8'h00) else $error("state low bits read");
    clear_bit_a: assert property (rd_go && address == `CONTROL_ADDR
        |=> !read_data[`CTL_CLEAR_ALL]) else $error("clear bit read one");
    flag_pulse_a: assert property (|unit_event_flag |=>
        (unit_event_flag & $past(unit_event_flag)) == 4'h0)
        else $error("event flag longer than one cycle");
    flag_cause_a: assert property (|unit_event_flag |->
        ((($past(capture_pins, 3) ^ $past(capture_pins, 8))
        & unit_event_flag) == unit_event_flag))
        else $error("event flag without pin edge");
    quiet_pins_a: assert property ($stable(capture_pins) [*8] |=>
        unit_event_flag == 4'h0) else $error("event flag on quiet pins");
    adc_flag_a: assert property (adc_start |-> unit_event_flag[3])
        else $error("converter start without unit 4 event");
endmodule

bind capture_fifo_stacks capture_fifo_stacks_props u_props (
    .clock           (clock),
    .nrst            (nrst),
    .clock_enable    (clock_enable),
    .capture_pins    (capture_pins),
    .address         (address),
    .read_strobe     (read_strobe),
    .adc_start       (adc_start),
    .read_data       (read_data),
    .unit_event_flag (unit_event_flag)
);

//--- bench/capture_source.sv
// Far-side model: capture pins and the two timer counts
`timescale 1ns/100ps
module capture_source (
    input  wire logic  clock,
    output logic [3:0] capture_pins,
    output logic [15:0] timer2_count,
    output logic [15:0] timer3_count
);
    initial begin
        capture_pins = 4'h0;
        timer2_count = 16'h0000;
        timer3_count = 16'hffff;
    end

    // Timers held across the capture window so the latched count is known
    task automatic toggle(input int u, input logic [15:0] v);
        @(posedge clock);
        timer2_count <= v;
        timer3_count <= ~v;
        capture_pins[u] <= ~capture_pins[u];
        repeat (12) @(posedge clock);
    endtask
endmodule

//--- bench/capture_fifo_stacks_bench.sv
// Register-level tests of the four capture stacks
`timescale 1ns/100ps
`include "capture_map.svh"
module capture_fifo_stacks_bench;
    logic        clock, nrst, clock_enable, read_strobe, write_strobe;
    logic [3:0]  capture_pins, unit_event_flag;
    logic [15:0] timer2_count, timer3_count, address, write_data;
    logic [15:0] read_data;
    logic        adc_start;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          flag_seen [4] = '{default: 0};
    int          adc_seen = 0;

    capture_source u_src (.clock(clock), .capture_pins(capture_pins),
        .timer2_count(timer2_count), .timer3_count(timer3_count));
    capture_fifo_stacks #(.WIDTH(16)) u_dut (.clock(clock), .nrst(nrst),
        .clock_enable(clock_enable), .capture_pins(capture_pins),
        .timer2_count(timer2_count), .timer3_count(timer3_count),
        .address(address), .read_strobe(read_strobe),
        .write_strobe(write_strobe), .write_data(write_data),
        .read_data(read_data), .unit_event_flag(unit_event_flag),
        .adc_start(adc_start));

    // ======================================================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, expected %h",
                $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1;
        check(read_data, exp);
    endtask

    task automatic final_report;
        $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Event outputs counted away from their launching edge
    always @(negedge clock) begin
        for (int i = 0; i < 4; i++) begin
            if (unit_event_flag[i] === 1'b1)
                flag_seen[i]++;
        end
        if (adc_start === 1'b1)
            adc_seen++;
    end

    // ======================================================================
    // Clock, watchdog and test sequence
    initial clock = 1'b0;
    always #25 clock = ~clock;

    initial begin
        repeat (5000) @(posedge clock);
        mismatches++;
        final_report();
    end

    initial begin
        nrst = 1'b0;
        clock_enable = 1'b1;
        address = 16'h0000;
        read_strobe = 1'b0;
        write_strobe = 1'b0;
        write_data = 16'h0000;
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        rd(`STATE_ADDR, 16'h0000);
        rd(`CONTROL_ADDR, 16'h0000);
        wr(`CONTROL_ADDR, 16'hbc6d);
        rd(`CONTROL_ADDR, 16'h3c6d);
        u_src.toggle(0, 16'h0011);
        rd(`STATE_ADDR, 16'h0100);
        u_src.toggle(0, 16'h0022);
        u_src.toggle(0, 16'h0033);
        rd(`STATE_ADDR, 16'h0200);
        rd(`STACK1_ADDR, 16'h0011);
        rd(`STATE_ADDR, 16'h0100);
        rd(`STACK1_ADDR, 16'h0033);
        rd(`STATE_ADDR, 16'h0000);
        rd(`STACK1_ADDR, 16'h0033);
        rd(`STATE_ADDR, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            u_src.toggle(0, 16'h0000);
            u_src.toggle(0, 16'h0044 + 16'(i * 17));
        end
        rd(`STATE_ADDR, 16'h0300);
        wr(`STATE_ADDR, 16'h0001);
        rd(`STATE_ADDR, 16'h0200);
        rd(`STACK1_ADDR, 16'h0055);
        rd(`STATE_ADDR, 16'h0100);
        wr(`STATE_ADDR, 16'hff00);
        rd(`STATE_ADDR, 16'h0100);
        wr(`STATE_ADDR, 16'h0001);
        rd(`STATE_ADDR, 16'h0000);
        u_src.toggle(2, 16'h0100);
        u_src.toggle(2, 16'h0200);
        rd(`STATE_ADDR, 16'h2000);
        rd(`STACK3_ADDR, 16'hfeff);
        u_src.toggle(1, 16'h0300);
        u_src.toggle(1, 16'h0400);
        rd(`STATE_ADDR, 16'h1400);
        rd(`STACK2_ADDR, 16'h0400);
        @(posedge clock);
        clock_enable <= 1'b0;
        rd(`STACK3_ADDR, 16'h0400);
        @(posedge clock);
        clock_enable <= 1'b1;
        rd(`STATE_ADDR, 16'h1000);
        u_src.toggle(3, 16'h0500);
        wr(`CONTROL_ADDR, 16'hb46d);
        u_src.toggle(3, 16'h0600);
        u_src.toggle(3, 16'h0700);
        rd(`STATE_ADDR, 16'h5000);
        rd(`STACK4_ADDR, 16'hfaff);
        wr(`CONTROL_ADDR, 16'hbd6d);
        u_src.toggle(3, 16'h0800);
        u_src.toggle(3, 16'h0900);
        rd(`STACK4_ADDR, 16'hf6ff);
        wr(`CONTROL_ADDR, 16'h3c6d);
        rd(`STATE_ADDR, 16'h0000);
        rd(`STACK3_ADDR, 16'h0000);
        rd(`CONTROL_ADDR, 16'h3c6d);
        rd(16'h7421, 16'h0000);
        check(16'(flag_seen[0]), 16'h0005);
        check(16'(flag_seen[1]), 16'h0001);
        check(16'(flag_seen[2]), 16'h0002);
        check(16'(flag_seen[3]), 16'h0002);
        check(16'(adc_seen), 16'h0001);
        final_report();
    end
endmodule
